// ---- common/ffsa_pkg.sv ----
// Constants, field positions and carrier types for the fault flag
// status aggregator. Shared by the top module and the flag bank.
// Assumes a single 50 MHz clock domain with active-low async reset.
package ffsa_pkg;

    // Clock rate and response latency
    localparam int CLK_PERIOD_NS   = 20;     // REF_CLK period
    localparam int FAULT_LAT_NS    = 20;     // Detect-to-flag time
    localparam int FAULT_LAT_CYC   = (FAULT_LAT_NS + CLK_PERIOD_NS - 1)
                                     / CLK_PERIOD_NS;

    // Register widths
    localparam int SUP_W = 16;               // Supply status flags
    localparam int CLK_W = 3;                // Clock status flags
    localparam int DIG_W = 4;                // Digital status flags
    localparam int STS_W = 16;               // Upper/lower status words
    localparam int CNT_W = 2;                // Rolling tally width

    // Supply flags with a checking circuit (OV, UV, OSC, ground pins)
    localparam logic [15:0] SUP_DIAG_MASK = 16'hE1FF;
    // Digital status: three sections then the memory checksum
    localparam int DIG_MEM_BIT = 3;
    // Clock status: frequency compare, osc watchdog, main watchdog
    localparam int CLK_FREQ_BIT = 0;

    // Upper status word fields
    localparam int UP_RESET_BIT  = 15;
    localparam int UP_COMM_LSB   = 11;       // Four comm flags [14:11]
    localparam int UP_CMD_LSB    = 7;        // Command response [10:7]
    localparam int UP_LOCK_BIT   = 6;
    localparam int UP_CLKSRC_BIT = 5;
    localparam int UP_MODE_BIT   = 4;
    // Lower status word fields
    localparam int LO_SEQ_RUN_BIT = 15;
    localparam int LO_CONV_A_LSB  = 4;
    localparam int LO_CONV_B_LSB  = 2;
    localparam int LO_SEQ_LSB     = 0;

    // Reset values
    localparam logic [15:0] FLAGS_OK_N   = 16'hFFFF;  // No fault
    localparam logic        RST_FLAG_RST = 1'h0;      // Reset seen
    localparam logic [3:0]  COMM_OK_N    = 4'hF;

    // Host clear target word
    typedef enum logic [1:0] {
        CLR_SUPPLY  = 2'h0,
        CLR_CLOCK   = 2'h1,
        CLR_DIGITAL = 2'h2,
        CLR_UPPER   = 2'h3
    } ffsa_clr_sel_t;

    // Host write-one-to-clear request
    typedef struct packed {
        logic          we;                   // One-cycle write strobe
        ffsa_clr_sel_t sel;                  // Target word
        logic [15:0]   data;                 // Ones clear flags
    } ffsa_clr_t;

    // Serial frame events from the interface logic
    typedef struct packed {
        logic frame_start;                   // Pulse at frame start
        logic frame_end;                     // Pulse at frame end
        logic crc_err;                       // Valid with frame_end
        logic timeout_err;
        logic sclk_err;
        logic access_err;
    } ffsa_frame_t;

endpackage

// ---- logic/ffsa_flag_bank.sv ----
// Bank of sticky active-low fault flags with enable and diagnostic
// injection. Assumes clear strobes are one clock wide.
`timescale 1ns/100ps
module ffsa_flag_bank
    import ffsa_pkg::*;
#(
    parameter int W = 4
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] fault,     // Raw monitor detect
    input  wire logic [W-1:0] enable,    // Monitor enable
    input  wire logic [W-1:0] diag,      // Diagnostic injection
    input  wire logic         clr_we,    // Clear strobe
    input  wire logic [W-1:0] clr_data,  // Ones clear
    output logic      [W-1:0] flag_n     // Low means fault seen
);

    // Each flag holds its own state; a detect beats a clear
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_flag
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    flag_n[i] <= 1'h1;
                end else if (enable[i] && (fault[i] || diag[i])) begin
                    // Still faulty: latch or re-assert
                    flag_n[i] <= 1'h0;
                end else if (clr_we && clr_data[i]) begin
                    // Host write of one releases the flag
                    flag_n[i] <= 1'h1;
                end
            end
        end
    endgenerate

endmodule

// ---- logic/ffsa_top.sv ----
// Fault flag and status aggregator: monitor flags, comm flags,
// indicators and rolling tallies, all presented as plain ports.
// Assumes monitor and frame inputs are synchronous to REF_CLK.
`timescale 1ns/100ps
module ffsa_top
    import ffsa_pkg::*;
(
    input  wire logic             REF_CLK,
    input  wire logic             RST_N,
    input  wire logic [SUP_W-1:0] SUPPLY_FAULT,
    input  wire logic [SUP_W-1:0] SUPPLY_MON_EN,
    input  wire logic [SUP_W-1:0] SUPPLY_DIAG_EN,
    input  wire logic [CLK_W-1:0] CLOCK_FAULT,
    input  wire logic [CLK_W-1:0] CLOCK_MON_EN,
    input  wire logic             MAIN_CLOCK_HIGH_CHECK_ENABLE,
    input  wire logic             MAIN_CLOCK_LOW_CHECK_ENABLE,
    input  wire logic [CLK_W-1:1] CLOCK_WD_DIAG_EN,
    input  wire logic [2:0]       SECTION_CHECKSUM_FAULT,
    input  wire logic [2:0]       SECTION_CHECKSUM_ENABLE,
    input  wire logic             MEMORY_CHECKSUM_FAULT,
    input  wire logic [1:0]       MEMORY_CHECKSUM_DIAG_SEL,
    input  wire ffsa_frame_t      FRAME,
    input  wire logic             TIMEOUT_MON_EN,
    input  wire logic             SCLK_COUNT_MON_EN,
    input  wire ffsa_clr_t        HOST_CLR,
    input  wire logic [3:0]       CMD_RESPONSE,
    input  wire logic             LOCK_STATE,
    input  wire logic             CLOCK_SOURCE,
    input  wire logic             OPERATING_MODE,
    input  wire logic             SEQUENCER_BUSY,
    input  wire logic             CONV_A_DONE,
    input  wire logic             CONV_B_DONE,
    input  wire logic             SEQUENCE_DONE,
    output logic      [SUP_W-1:0] SUPPLY_STATUS,
    output logic      [CLK_W-1:0] CLOCK_STATUS,
    output logic      [DIG_W-1:0] DIGITAL_STATUS,
    output logic      [STS_W-1:0] STATUS_UPPER,
    output logic      [STS_W-1:0] STATUS_LOWER
);

    // Decode of a host clear aimed at one status word
    function automatic logic clr_hit(input ffsa_clr_t c,
                                     input ffsa_clr_sel_t s);
        return c.we && (c.sel == s);
    endfunction

    logic             clr_sup;           // Clear aimed at supply word
    logic             clr_clk;           // Clear aimed at clock word
    logic             clr_dig;           // Clear aimed at digital word
    logic             clr_up;            // Clear aimed at upper word
    logic [CLK_W-1:0] clk_diag;          // Clock diag injection
    logic [DIG_W-1:0] dig_fault;         // Digital raw detects
    logic [DIG_W-1:0] dig_en;            // Digital enables
    logic [DIG_W-1:0] dig_diag;          // Digital diag injection
    logic             reset_occurred_flag_n_q;
    logic [3:0]       comm_flag_n_q;     // crc, timeout, sclk, access
    logic [3:0]       frame_err;         // Qualified frame errors
    logic             clean_frame_q;     // Last frame ended clean
    logic [3:0]       cmd_q;             // Command response copy
    logic             lock_q;
    logic             clksrc_q;
    logic             mode_q;
    logic             sequencer_running_q;
    logic [CNT_W-1:0] current_adc_a_conv_tally_q;
    logic [CNT_W-1:0] current_adc_b_conv_tally_q;
    logic [CNT_W-1:0] sequence_tally_q;

    assign clr_sup = clr_hit(HOST_CLR, CLR_SUPPLY);
    assign clr_clk = clr_hit(HOST_CLR, CLR_CLOCK);
    assign clr_dig = clr_hit(HOST_CLR, CLR_DIGITAL);
    assign clr_up  = clr_hit(HOST_CLR, CLR_UPPER);

    // Supply word: sixteen sticky flags, diag only where circuit exists
    ffsa_flag_bank #(.W(SUP_W)) u_supply (
        .clk      (REF_CLK),
        .rst_n    (RST_N),
        .fault    (SUPPLY_FAULT),
        .enable   (SUPPLY_MON_EN),
        .diag     (SUPPLY_DIAG_EN & SUP_DIAG_MASK),
        .clr_we   (clr_sup),
        .clr_data (HOST_CLR.data[SUP_W-1:0]),
        .flag_n   (SUPPLY_STATUS)
    );

    // Either frequency check direction exercises the clock compare
    always_comb begin
        clk_diag               = {CLOCK_WD_DIAG_EN, 1'h0};
        clk_diag[CLK_FREQ_BIT] = MAIN_CLOCK_HIGH_CHECK_ENABLE
                               | MAIN_CLOCK_LOW_CHECK_ENABLE;
    end

    // Clock word: compare and two watchdogs
    ffsa_flag_bank #(.W(CLK_W)) u_clock (
        .clk      (REF_CLK),
        .rst_n    (RST_N),
        .fault    (CLOCK_FAULT),
        .enable   (CLOCK_MON_EN),
        .diag     (clk_diag),
        .clr_we   (clr_clk),
        .clr_data (HOST_CLR.data[CLK_W-1:0]),
        .flag_n   (CLOCK_STATUS)
    );

    // Memory checksum has no enable; any nonzero diag code injects
    always_comb begin
        dig_fault = {MEMORY_CHECKSUM_FAULT, SECTION_CHECKSUM_FAULT};
        dig_en    = {1'h1, SECTION_CHECKSUM_ENABLE};
        dig_diag  = {|MEMORY_CHECKSUM_DIAG_SEL, 3'h0};
    end

    // Digital word: three sections plus memory checksum
    ffsa_flag_bank #(.W(DIG_W)) u_digital (
        .clk      (REF_CLK),
        .rst_n    (RST_N),
        .fault    (dig_fault),
        .enable   (dig_en),
        .diag     (dig_diag),
        .clr_we   (clr_dig),
        .clr_data (HOST_CLR.data[DIG_W-1:0]),
        .flag_n   (DIGITAL_STATUS)
    );

    // Reset flag is low after any reset until the host clears it
    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            reset_occurred_flag_n_q <= RST_FLAG_RST;
        end else if (clr_up && HOST_CLR.data[UP_RESET_BIT]) begin
            reset_occurred_flag_n_q <= 1'h1;
        end
    end

    // Only timeout and clock count monitors can be switched off
    assign frame_err = {FRAME.crc_err,
                        FRAME.timeout_err & TIMEOUT_MON_EN,
                        FRAME.sclk_err & SCLK_COUNT_MON_EN,
                        FRAME.access_err};

    // Remember whether the last finished frame was clean
    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            clean_frame_q <= 1'h0;
        end else if (FRAME.frame_end) begin
            clean_frame_q <= ~|frame_err;
        end else if (FRAME.frame_start) begin
            clean_frame_q <= 1'h0;     // Used once, at this start
        end
    end

    // Comm flags: set at a faulty frame end, self-heal at the start of the frame after a clean one
    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            comm_flag_n_q <= COMM_OK_N;
        end else if (FRAME.frame_end) begin
            // New errors win over any recovery
            comm_flag_n_q <= comm_flag_n_q & ~frame_err;
        end else if (FRAME.frame_start && clean_frame_q) begin
            comm_flag_n_q <= COMM_OK_N;
        end
    end

    // Indicator copies so every output leaves a flop
    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            cmd_q               <= 4'h0;
            lock_q              <= 1'h0;
            clksrc_q            <= 1'h0;
            mode_q              <= 1'h0;
            sequencer_running_q <= 1'h0;
        end else begin
            cmd_q               <= CMD_RESPONSE;
            lock_q              <= LOCK_STATE;
            clksrc_q            <= CLOCK_SOURCE;
            mode_q              <= OPERATING_MODE;
            sequencer_running_q <= SEQUENCER_BUSY;
        end
    end

    // Rolling tallies wrap silently; host compares successive reads
    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            current_adc_a_conv_tally_q <= 2'h0;
            current_adc_b_conv_tally_q <= 2'h0;
            sequence_tally_q           <= 2'h0;
        end else begin
            if (CONV_A_DONE) begin
                current_adc_a_conv_tally_q <=
                    current_adc_a_conv_tally_q + 2'h1;
            end
            if (CONV_B_DONE) begin
                current_adc_b_conv_tally_q <=
                    current_adc_b_conv_tally_q + 2'h1;
            end
            if (SEQUENCE_DONE) begin
                sequence_tally_q <= sequence_tally_q + 2'h1;
            end
        end
    end

    // Upper word assembly, unused bits read zero
    always_comb begin
        STATUS_UPPER = 16'h0000;
        STATUS_UPPER[UP_RESET_BIT]              = reset_occurred_flag_n_q;
        STATUS_UPPER[UP_COMM_LSB +: 4]          = comm_flag_n_q;
        STATUS_UPPER[UP_CMD_LSB +: 4]           = cmd_q;
        STATUS_UPPER[UP_LOCK_BIT]               = lock_q;
        STATUS_UPPER[UP_CLKSRC_BIT]             = clksrc_q;
        STATUS_UPPER[UP_MODE_BIT]               = mode_q;
    end

    // Lower word assembly, unused bits read zero
    always_comb begin
        STATUS_LOWER = 16'h0000;
        STATUS_LOWER[LO_SEQ_RUN_BIT]            = sequencer_running_q;
        STATUS_LOWER[LO_CONV_A_LSB +: CNT_W]    = current_adc_a_conv_tally_q;
        STATUS_LOWER[LO_CONV_B_LSB +: CNT_W]    = current_adc_b_conv_tally_q;
        STATUS_LOWER[LO_SEQ_LSB +: CNT_W]       = sequence_tally_q;
    end

    // Checks of flag behaviour against its causes
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RST_N);

    a_supply_fault_sets: assert property (
        SUPPLY_FAULT[0] && SUPPLY_MON_EN[0] |=> !SUPPLY_STATUS[0])
        else $error("Supply fault did not pull flag low");

    a_fault_latency: assert property (
        $rose(CLOCK_FAULT[2] && CLOCK_MON_EN[2])
        |-> ##[1:1] !CLOCK_STATUS[2])
        else $error("Clock flag missed its latency");

    a_flag_sticky: assert property (
        !SUPPLY_STATUS[1] && !(clr_sup && HOST_CLR.data[1])
        |=> !SUPPLY_STATUS[1])
        else $error("Sticky supply flag released on its own");

    a_clear_releases: assert property (
        clr_dig && HOST_CLR.data[0] && !(SECTION_CHECKSUM_ENABLE[0]
        && SECTION_CHECKSUM_FAULT[0]) |=> DIGITAL_STATUS[0])
        else $error("Write of one did not clear flag");

    a_clear_blocked: assert property (
        clr_sup && HOST_CLR.data[2] && SUPPLY_FAULT[2]
        && SUPPLY_MON_EN[2] |=> !SUPPLY_STATUS[2])
        else $error("Live fault lost to a clear");

    a_comm_recover: assert property (
        FRAME.frame_end && !(|frame_err) ##1
        (!FRAME.frame_end && !FRAME.frame_start)[*2] ##1
        (FRAME.frame_start && !FRAME.frame_end)
        |=> STATUS_UPPER[UP_COMM_LSB +: 4] == COMM_OK_N)
        else $error("Comm flags did not self-heal");

    a_disabled_quiet: assert property (
        SUPPLY_STATUS[3] && !SUPPLY_MON_EN[3]
        && !(clr_sup && HOST_CLR.data[3]) |=> SUPPLY_STATUS[3])
        else $error("Disabled monitor reported a fault");

    a_diag_injects: assert property (
        CLOCK_MON_EN[CLK_FREQ_BIT] && MAIN_CLOCK_LOW_CHECK_ENABLE
        |=> !CLOCK_STATUS[CLK_FREQ_BIT])
        else $error("Clock diag did not inject a fault");

    a_memory_always: assert property (
        MEMORY_CHECKSUM_DIAG_SEL != 2'h0 |=> !DIGITAL_STATUS[DIG_MEM_BIT])
        else $error("Memory checksum diag not reported");

    a_timeout_gated: assert property (
        FRAME.frame_end && FRAME.timeout_err && !TIMEOUT_MON_EN
        && STATUS_UPPER[UP_COMM_LSB + 2] |=> STATUS_UPPER[UP_COMM_LSB + 2])
        else $error("Disabled timeout monitor set its flag");

    a_cmd_follows: assert property (
        1'b1 |=> STATUS_UPPER[UP_CMD_LSB +: 4] == $past(CMD_RESPONSE))
        else $error("Command response not copied");

    a_tally_counts: assert property (
        CONV_A_DONE |=> STATUS_LOWER[LO_CONV_A_LSB +: CNT_W]
        == $past(current_adc_a_conv_tally_q) + 2'h1)
        else $error("Conversion tally did not advance");

    c_supply_clear: cover property (
        !SUPPLY_STATUS[0] ##1 clr_sup ##1 SUPPLY_STATUS[0]);
    c_comm_heal: cover property (
        !STATUS_UPPER[UP_COMM_LSB] ##[1:40] STATUS_UPPER[UP_COMM_LSB]);
    c_tally_wrap: cover property (
        STATUS_LOWER[LO_SEQ_LSB +: CNT_W] == 2'h3 ##1 SEQUENCE_DONE
        ##1 STATUS_LOWER[LO_SEQ_LSB +: CNT_W] == 2'h0);

endmodule

// ---- sim/ffsa_host_model.sv ----
// Host side model: write-one-to-clear requests and serial frame events.
// Assumes the bench refreshes rnd on each rising edge of clk.
`timescale 1ns/100ps
module ffsa_host_model
    import ffsa_pkg::*;
(
    input  wire logic        clk,
    input  wire logic [31:0] rnd,
    output ffsa_clr_t        host_clr,
    output ffsa_frame_t      frame
);
    logic in_frame_q;  // Between start and end pulses

    // Idle values before the first falling edge
    initial begin
        host_clr = '0;
        frame = '0;
        in_frame_q = 1'b0;
    end

    // Requests change on the falling edge only, one cycle wide
    always @(negedge clk) begin
        host_clr.we <= (rnd[3:0] == 4'h0);
        host_clr.sel <= ffsa_clr_sel_t'(rnd[5:4]);
        // Ones clear, zeros leave the flag alone
        host_clr.data <= rnd[31:16];
        // One update of frame per edge, so no glitch between branches
        if (!in_frame_q && rnd[9:6] == 4'h0) begin
            frame <= {2'h2, rnd[13:10]};
            in_frame_q <= 1'b1;
        end else if (in_frame_q && rnd[9:6] == 4'h1) begin
            // About half the frames end clean
            frame <= {2'h1, rnd[13:10] & {4{rnd[14]}}};
            in_frame_q <= 1'b0;
        end else begin
            // Junk on error lines outside frame end, which must not count
            frame <= {2'h0, rnd[13:10]};
        end
    end
endmodule

// ---- sim/ffsa_top_tb_top.sv ----
// Random bench for the fault flag aggregator with a cycle model.
// Assumes the host model drives clears and frames on falling edges.
`timescale 1ns/100ps
module ffsa_top_tb_top;
    import ffsa_pkg::*;
    logic        ref_clk, rst_n;          // Clock, reset
    logic [15:0] sup_f, sup_en, sup_dg;   // Supply monitors
    logic [2:0]  clk_f, clk_en;           // Clock monitors
    logic        hi_en, lo_en;            // Frequency check injects
    logic [2:1]  wd_dg;                   // Watchdog injects
    logic [2:0]  sec_f, sec_en;           // Section checksums
    logic        mem_f, to_en, sc_en;
    logic [1:0]  mem_sel;
    logic [3:0]  cmd;
    logic        lock, csrc, mode, busy, da, db, ds;
    logic [31:0] rnd;                     // Host model randomness
    ffsa_clr_t   host_clr;
    ffsa_frame_t frame;
    logic [15:0] sup_s, up_s, lo_s;       // Design outputs
    logic [2:0]  clk_s;
    logic [3:0]  dig_s;
    int          error_cnt, n_compared;
    int          m_sup, m_clk, m_dig, m_up, m_lo, arm, q, cm;  // Model

    ffsa_host_model host (.clk(ref_clk), .rnd(rnd), .host_clr(host_clr),
                          .frame(frame));
    ffsa_top DUT (
        .REF_CLK(ref_clk), .RST_N(rst_n),
        .SUPPLY_FAULT(sup_f), .SUPPLY_MON_EN(sup_en),
        .SUPPLY_DIAG_EN(sup_dg), .CLOCK_FAULT(clk_f),
        .CLOCK_MON_EN(clk_en), .MAIN_CLOCK_HIGH_CHECK_ENABLE(hi_en),
        .MAIN_CLOCK_LOW_CHECK_ENABLE(lo_en), .CLOCK_WD_DIAG_EN(wd_dg),
        .SECTION_CHECKSUM_FAULT(sec_f), .SECTION_CHECKSUM_ENABLE(sec_en),
        .MEMORY_CHECKSUM_FAULT(mem_f), .MEMORY_CHECKSUM_DIAG_SEL(mem_sel),
        .FRAME(frame), .TIMEOUT_MON_EN(to_en),
        .SCLK_COUNT_MON_EN(sc_en), .HOST_CLR(host_clr),
        .CMD_RESPONSE(cmd), .LOCK_STATE(lock), .CLOCK_SOURCE(csrc),
        .OPERATING_MODE(mode), .SEQUENCER_BUSY(busy),
        .CONV_A_DONE(da), .CONV_B_DONE(db), .SEQUENCE_DONE(ds),
        .SUPPLY_STATUS(sup_s), .CLOCK_STATUS(clk_s),
        .DIGITAL_STATUS(dig_s), .STATUS_UPPER(up_s), .STATUS_LOWER(lo_s)
    );

    // Free running 50 MHz clock
    initial begin
        ref_clk = 1'b0;
        forever #(CLK_PERIOD_NS / 2) ref_clk = ~ref_clk;
    end

    // Fresh host randomness each rising edge, used on the falling one
    always @(posedge ref_clk) rnd <= $urandom;

    // Clear bits aimed at one status word, zero otherwise
    function automatic int clr(ffsa_clr_sel_t s);
        return (host_clr.we && host_clr.sel == s) ? host_clr.data : 0;
    endfunction

    // Reference model: set wins over clear, clear only when detect is gone
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            m_sup = 16'hFFFF;
            m_clk = 7;
            m_dig = 15;
            m_up = 16'h7800;  // Reset seen, comm flags clean
            m_lo = 0;
            arm = 0;
        end else begin
            m_sup = ~(sup_en & (sup_f | sup_dg & SUP_DIAG_MASK))
                    & (m_sup | clr(CLR_SUPPLY)) & 16'hFFFF;
            m_clk = ~(clk_en & (clk_f | {wd_dg, hi_en | lo_en}))
                    & (m_clk | clr(CLR_CLOCK)) & 7;
            m_dig = ~{mem_f | (mem_sel != 2'h0), sec_f & sec_en}
                    & (m_dig | clr(CLR_DIGITAL)) & 15;
            // Timeout and clock count errors only count when enabled
            q = frame[3:0] & {1'b1, to_en, sc_en, 1'b1};
            cm = (m_up >> 11) & 15;
            if (frame.frame_end) begin
                cm = cm & ~q;
                arm = (q == 0);
            end else if (frame.frame_start && arm) begin
                cm = 15;
                arm = 0;
            end
            m_up = (m_up | clr(CLR_UPPER)) & 16'h8000 | cm << 11
                   | cmd << 7 | lock << 6 | csrc << 5 | mode << 4;
            m_lo = busy << 15 | ((m_lo >> 4) + da) % 4 << 4
                   | ((m_lo >> 2) + db) % 4 << 2 | (m_lo + ds) % 4;
        end
    end

    // One comparison, counted; mismatches reported at once
    task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // Every output against the model
    task automatic compare_all();
        chk("supply", sup_s, 16'(m_sup));
        chk("clock", 16'(clk_s), 16'(m_clk));
        chk("digital", 16'(dig_s), 16'(m_dig));
        chk("upper", up_s, 16'(m_up));
        chk("lower", lo_s, 16'(m_lo));
    endtask

    // Sparse faults and injects, mostly enabled monitors
    task automatic drive_rand();
        sup_f = 16'($urandom & $urandom & $urandom);
        sup_en = 16'(~($urandom & $urandom));
        sup_dg = 16'($urandom & $urandom & $urandom & $urandom);
        {clk_f, wd_dg, hi_en, lo_en, sec_f, mem_f, mem_sel}
            = 13'($urandom & $urandom & $urandom);
        {clk_en, sec_en, to_en, sc_en} = 8'(~($urandom & $urandom));
        {cmd, lock, csrc, mode, busy, da, db, ds} = 11'($urandom);
    endtask

    // Counts, verdict and end of run
    task automatic complete_run();
        $display("Compared %0d, mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Main sequence, with a second reset in mid run
    initial begin
        error_cnt = 0;
        n_compared = 0;
        rst_n = 1'b0;
        rnd = $urandom(70015);
        drive_rand();
        repeat (10) begin
            @(negedge ref_clk);
            compare_all();
        end
        rst_n = 1'b1;
        for (int i = 0; i < 4000; i++) begin
            @(negedge ref_clk);
            compare_all();
            if (i == 2000) rst_n = 1'b0;
            if (i == 2003) rst_n = 1'b1;
            drive_rand();
        end
        complete_run();
    end

    // Cut a hang short at twice the expected run time
    initial begin
        #(4010 * CLK_PERIOD_NS * 2);
        error_cnt++;
        complete_run();
    end
endmodule
